// file: verilog/stats_glue_cfg.svh
// Constants for the statistics-unit glue and its host-side partner.
// Assumes a single 40 MHz clock and a synchronous active-low reset.
// Notes on behaviour
// - Gated select never precedes gated read/write
// - Host strobes follow its raw select
// - Gated read/write derived from host write strobe only
// - Gated select derived from raw select
// - Address and data bypass glue; every control output is registered
// - Serial line buffers get true, inverted direction
// - Data-valid qualified by transmit-ready
// - Host writes use four wait states
// - Host reads use five wait states
// - Host ends access by wait count
// - One command reads all counters, then interrupts
// - One unit serves up to 16 controllers
// - Statistics kept locally, read back over bus
`ifndef STATS_GLUE_CFG_SVH
`define STATS_GLUE_CFG_SVH
`define CLK_PERIOD_NS 25
`define WRITE_WAIT_STATES 4'h4
`define READ_WAIT_STATES 4'h5
`define MAX_CONTROLLERS 5'h10
`define ADDR_WIDTH 8
`define DATA_WIDTH 8
`endif

// file: verilog/stats_glue_pkg.sv
// Types used by the host end of the statistics-unit glue.
// Assumes the constants header is available on the include path.
package stats_glue_pkg;
  typedef enum logic [3:0] {
    HOST_IDLE = 4'h1,
    HOST_SELECT = 4'h2,
    HOST_STROBE = 4'h4,
    HOST_RELEASE = 4'h8
  } host_state_e;
endpackage

// file: verilog/stats_glue_if.sv
// Pins between the host processor end and the statistics-unit glue.
// Assumes one clock shared by both ends; the bench joins the two.
`timescale 1ns/1ps
`include "stats_glue_cfg.svh"
interface stats_glue_if;
  logic ioReadB;
  logic ioWriteB;
  logic hostStatsSelectB;
  logic [`ADDR_WIDTH-1:0] address;
  logic [`DATA_WIDTH-1:0] writeData;
  logic [`DATA_WIDTH-1:0] readData;
  modport host (
    output ioReadB,
    output ioWriteB,
    output hostStatsSelectB,
    output address,
    output writeData,
    input readData
  );
  modport glue (
    input ioReadB,
    input ioWriteB,
    input hostStatsSelectB,
    input address,
    input writeData,
    output readData
  );
endinterface

// file: verilog/stats_host_end.sv
// Host processor end: runs one I/O access with programmed wait states.
// Assumes the user holds request until accepted by the done pulse.
`timescale 1ns/1ps
`include "stats_glue_cfg.svh"
module stats_host_end (
  input wire logic clk, // 40 MHz clock
  input wire logic rst_b, // Synchronous reset, active low
  stats_glue_if.host bus, // Pins toward the glue
  input wire logic request, // Start one access
  input wire logic writeNotRead, // 1 write, 0 read
  input wire logic [`ADDR_WIDTH-1:0] reqAddress, // Register address
  input wire logic [`DATA_WIDTH-1:0] reqData, // Write data
  output logic done, // One-cycle end of access
  output logic [`DATA_WIDTH-1:0] readResult // Captured read data
);
  typedef struct packed {
    stats_glue_pkg::host_state_e state;
    logic [3:0] waitCount;
    logic isWrite;
    logic ioReadB;
    logic ioWriteB;
    logic selectB;
    logic [`ADDR_WIDTH-1:0] address;
    logic [`DATA_WIDTH-1:0] writeData;
    logic done;
    logic [`DATA_WIDTH-1:0] readResult;
  } host_s;

  host_s state_reg;
  host_s state_next;

  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    case (state_reg.state)
      stats_glue_pkg::HOST_IDLE: begin
        if (request) begin
          // Select first, strobes a cycle later
          state_next.selectB = 1'b0;
          state_next.address = reqAddress;
          state_next.writeData = reqData;
          state_next.isWrite = writeNotRead;
          state_next.state = stats_glue_pkg::HOST_SELECT;
        end
      end
      stats_glue_pkg::HOST_SELECT: begin
        state_next.ioWriteB = ~state_reg.isWrite;
        state_next.ioReadB = state_reg.isWrite;
        // Ready input unused; cycle length fixed
        state_next.waitCount = state_reg.isWrite ? `WRITE_WAIT_STATES : `READ_WAIT_STATES;
        state_next.state = stats_glue_pkg::HOST_STROBE;
      end
      stats_glue_pkg::HOST_STROBE: begin
        if (state_reg.waitCount == 4'h0) begin
          if (!state_reg.isWrite) begin
            state_next.readResult = bus.readData;
          end
          state_next.ioReadB = 1'b1;
          state_next.ioWriteB = 1'b1;
          state_next.state = stats_glue_pkg::HOST_RELEASE;
        end else begin
          state_next.waitCount = state_reg.waitCount - 4'h1;
        end
      end
      stats_glue_pkg::HOST_RELEASE: begin
        state_next.selectB = 1'b1;
        state_next.done = 1'b1;
        state_next.state = stats_glue_pkg::HOST_IDLE;
      end
      default: begin
        state_next.state = stats_glue_pkg::HOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= '{state: stats_glue_pkg::HOST_IDLE, waitCount: 4'h0, isWrite: 1'b0,
                     ioReadB: 1'b1, ioWriteB: 1'b1, selectB: 1'b1,
                     address: '0, writeData: '0, done: 1'b0, readResult: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign bus.ioReadB = state_reg.ioReadB;
  assign bus.ioWriteB = state_reg.ioWriteB;
  assign bus.hostStatsSelectB = state_reg.selectB;
  assign bus.address = state_reg.address;
  assign bus.writeData = state_reg.writeData;
  assign done = state_reg.done;
  assign readResult = state_reg.readResult;
endmodule

// file: verilog/stats_glue_logic.sv
// Glue end: conditions select and read/write for the statistics unit,
// drives the serial-line transceiver and qualifies management data-valid.
// Assumes host pins synchronous to clk; address/data pass straight through.
`timescale 1ns/1ps
`include "stats_glue_cfg.svh"
module stats_glue_logic (
  input wire logic clk, // 40 MHz clock
  input wire logic rst_b, // Synchronous reset, active low
  stats_glue_if.glue bus, // Pins from the host
  input wire logic [`DATA_WIDTH-1:0] unitReadData, // Data from statistics unit
  output logic [`ADDR_WIDTH-1:0] unitAddress, // Address to statistics unit
  output logic [`DATA_WIDTH-1:0] unitWriteData, // Data to statistics unit
  output logic gatedRwLine, // 1 read, 0 write
  output logic gatedStatsSelectB, // Gated select, active low
  input wire logic serialIoDirection, // Unit's serial-line direction, 1 drives out
  output logic serialOutEnable, // Enable of outbound buffer
  output logic serialInEnableB, // Enable of inbound buffer, active low
  input wire logic mgmtDataValidB, // Raw management data-valid, active low
  input wire logic txReady, // Transmit-ready qualifier
  output logic qualDataValidB // Qualified data-valid to unit, active low
);
  typedef struct packed {
    logic rwLine;
    logic selectB;
    logic outEnable;
    logic inEnableB;
    logic dataValidB;
  } glue_s;

  glue_s state_reg;
  glue_s state_next;
  logic strobe;

  always_comb begin
    strobe = !bus.ioReadB || !bus.ioWriteB;
    state_next = state_reg;
    // Write while write strobe low, else read
    state_next.rwLine = bus.ioWriteB;
    // Select waits one cycle after rw settles, and drops at once
    state_next.selectB = !(!bus.hostStatsSelectB && strobe &&
                           (state_reg.rwLine == bus.ioWriteB));
    state_next.outEnable = serialIoDirection;
    state_next.inEnableB = serialIoDirection;
    // Noise on data-valid ignored unless transmit ready
    state_next.dataValidB = !(!mgmtDataValidB && txReady);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= '{rwLine: 1'b1, selectB: 1'b1, outEnable: 1'b0,
                     inEnableB: 1'b1, dataValidB: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  // Bypass paths
  // Counter sweep, interrupt and storage live in the unit itself;
  // the glue only carries its bus
  assign unitAddress = bus.address;
  assign unitWriteData = bus.writeData;
  assign bus.readData = unitReadData;
  assign gatedRwLine = state_reg.rwLine;
  assign gatedStatsSelectB = state_reg.selectB;
  assign serialOutEnable = state_reg.outEnable;
  assign serialInEnableB = state_reg.inEnableB;
  assign qualDataValidB = state_reg.dataValidB;
endmodule

// file: bench/stats_glue_sva.sv
// Checker on the host pins and the gated outputs toward the statistics unit.
// Assumes the bench instantiates it once, beside the interface.
`timescale 1ns/1ps
module stats_glue_sva (
  input wire logic clk, // Clock
  input wire logic rst_b, // Sync reset, active low
  input wire logic ioReadB, // Read strobe
  input wire logic ioWriteB, // Write strobe
  input wire logic hostStatsSelectB, // Raw select
  input wire logic gatedRwLine, // Gated read/write
  input wire logic gatedStatsSelectB // Gated select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  select_leads_strobe_a: assert property ($fell(ioWriteB) || $fell(ioReadB) |->
    $past(!hostStatsSelectB) && !hostStatsSelectB) else $error("strobe before select");
  write_wait_count_a: assert property ($fell(ioWriteB) |-> !ioWriteB [*5] ##1 ioWriteB)
    else $error("write strobe length wrong");
  read_wait_count_a: assert property ($fell(ioReadB) |-> !ioReadB [*6] ##1 ioReadB)
    else $error("read strobe length wrong");
  strobe_in_select_a: assert property (!ioWriteB || !ioReadB |-> !hostStatsSelectB)
    else $error("strobe outside select");
  rw_follows_write_a: assert property (1'b1 |=> gatedRwLine == $past(ioWriteB))
    else $error("read/write line wrong");
  rw_settled_first_a: assert property ($fell(gatedStatsSelectB) |->
    $stable(gatedRwLine)) else $error("select with moving read/write");
  select_after_strobe_a: assert property ($fell(ioWriteB) || $fell(ioReadB) |->
    ##2 !gatedStatsSelectB) else $error("gated select late");
  select_release_a: assert property ($rose(ioWriteB) || $rose(ioReadB) |=>
    gatedStatsSelectB) else $error("gated select held");
  cover property ($fell(ioWriteB));
  cover property ($fell(ioReadB));
  cover property ($rose(gatedStatsSelectB));
endmodule

// file: bench/tb_top.sv
// Bench: host end and glue joined through the interface, driven by tasks.
// Assumes the design files and the constants header on the include path.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'h0, rst_b = 1'h0, request = 1'h0, writeNotRead = 1'h0, done;
  logic serialIoDirection = 1'h0;
  logic [7:0] reqAddress = 8'h00, reqData = 8'h00, readResult, unitReadData = 8'h00;
  logic [7:0] unitAddress;
  logic [7:0] unitWriteData;
  logic gatedRwLine, gatedStatsSelectB, serialOutEnable, serialInEnableB, qualDataValidB;
  logic mgmtDataValidB = 1'h1, txReady = 1'h0;
  int num_errors = 0, checks = 0, n;
  always #12.5 clk = ~clk;
  stats_glue_if bus ();
  stats_host_end stats_host_end_inst (.clk(clk), .rst_b(rst_b), .bus(bus.host),
    .request(request), .writeNotRead(writeNotRead), .reqAddress(reqAddress),
    .reqData(reqData), .done(done), .readResult(readResult));
  stats_glue_logic stats_glue_logic_inst (.clk(clk), .rst_b(rst_b), .bus(bus.glue),
    .unitReadData(unitReadData), .unitAddress(unitAddress), .unitWriteData(unitWriteData),
    .gatedRwLine(gatedRwLine), .gatedStatsSelectB(gatedStatsSelectB),
    .serialIoDirection(serialIoDirection), .serialOutEnable(serialOutEnable),
    .serialInEnableB(serialInEnableB), .mgmtDataValidB(mgmtDataValidB),
    .txReady(txReady), .qualDataValidB(qualDataValidB));
  stats_glue_sva stats_glue_sva_inst (.clk(clk), .rst_b(rst_b), .ioReadB(bus.ioReadB),
    .ioWriteB(bus.ioWriteB), .hostStatsSelectB(bus.hostStatsSelectB),
    .gatedRwLine(gatedRwLine), .gatedStatsSelectB(gatedStatsSelectB));
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One host access; latency counted from the edge that takes the request
  task automatic access(logic wr, logic [7:0] a, logic [7:0] d);
    writeNotRead = wr;
    reqAddress = a;
    reqData = d;
    unitReadData = d;
    request = 1'h1;
    for (n = 1; n < 20; n++) begin
      @(negedge clk);
      if (done === 1'b1) break;
      if (n == 5) begin
        check({gatedStatsSelectB, gatedRwLine}, {1'b0, !wr});
        check(unitAddress, a);
        check(unitWriteData, d);
      end
    end
    if (n == 20) begin
      num_errors++;
      conclude();
    end else begin
      check(n, wr ? 8'h08 : 8'h09);
      if (!wr) check(readResult, d);
      check(gatedStatsSelectB, 1'b1);
      request = 1'h0;
      @(negedge clk);
    end
  endtask
  task automatic write_reg(logic [7:0] a, logic [7:0] d);
    access(1'b1, a, d);
  endtask
  // Stand-in unit returns the expected byte on the data bus
  task automatic read_reg(logic [7:0] a, logic [7:0] exp);
    access(1'b0, a, exp);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    check({gatedStatsSelectB, gatedRwLine, qualDataValidB, serialInEnableB, serialOutEnable},
      8'h1e);
    check(readResult, 8'h00);
    rst_b = 1'h1;
    write_reg(8'h00, 8'ha5);
    read_reg(8'hff, 8'h5a);
    read_reg(8'h3c, 8'hc3);
    write_reg(8'h81, 8'h7e);
    // Every combination of direction, data-valid and transmit-ready
    for (int i = 0; i < 8; i++) begin
      {txReady, mgmtDataValidB, serialIoDirection} = i[2:0];
      @(negedge clk);
      check({serialOutEnable, serialInEnableB}, {2{i[0]}});
      check(qualDataValidB, !(!i[1] && i[2]));
    end
    conclude();
  end
endmodule
